// file: src/test_obs_pkg.sv
`default_nettype none
package test_obs_pkg;
  // ----------------------------------------
  // serial frame layout
  // ----------------------------------------
  localparam logic [1:0] MODE_WRITE      = 2'h0;
  localparam logic [1:0] MODE_READ       = 2'h1;
  localparam logic [1:0] MODE_COMMAND    = 2'h3;
  localparam int         MODE_MSB        = 7;
  localparam int         MODE_LSB        = 6;
  localparam int         ADDR_MSB        = 5;
  // ----------------------------------------
  // direct command codes (values arbitrary)
  // ----------------------------------------
  localparam logic [5:0] CMD_TEST_ACCESS = 6'h3c;
  localparam logic [5:0] CMD_CLEAR_TEST  = 6'h2a;
  localparam logic [5:0] CMD_ADJUST_REG  = 6'h16;
  // ----------------------------------------
  // test register space
  // ----------------------------------------
  localparam logic [5:0] OBS_ADDR        = 6'h01;
  localparam logic [7:0] OBS_RESET       = 8'h00;
  localparam logic [7:0] OBS_WR_MASK     = 8'h0f;
  localparam int         SEL_MSB         = 3;
  localparam int         SEL_LSB         = 0;
  // ----------------------------------------
  // observation select codes
  // ----------------------------------------
  localparam logic [3:0] SEL_AM_PAIR     = 4'h1;
  localparam logic [3:0] SEL_PM_PAIR     = 4'h2;
  localparam logic [3:0] SEL_ANALOG_BOTH = 4'h3;
  localparam logic [3:0] SEL_DIGITAL_BOTH= 4'h4;
  localparam logic [3:0] SEL_STAGES      = 4'h5;
  localparam logic [3:0] SEL_COLL_AVOID  = 4'h9;
  localparam logic [3:0] SEL_TX_MOD      = 4'ha;
endpackage : test_obs_pkg
`default_nettype wire

// file: src/reader_test_observation_access.sv
// Operation
// - test registers sit outside the normal map and open only after the test access command.
// - test access followed by auto-incremented test register accesses in one frame is honoured.
// - deselecting the serial interface leaves the test register contents untouched.
// - test registers take their defaults at power-up and on the clear-test-registers command.
// - the observation register at test address 01h is 8-bit rw, bits 7..4 unused, reset zero.
// - bits 3..0 select what the two observation pins show, in normal operation as well.
// - codes 1..4 route amplitude and phase channel analog and digitized signals to the pins.
// - code 5 shows first and second receive stage, from phase channel if on, else amplitude.
// - code 9 shows logic channel selection and collision detector, with detectors enabled.
// - code 10 shows the digital transmit modulation and the phase-channel select signal.
// - after power is applied the device is in power-down with all registers at default.
// - the regulator adjustment command is refused while external regulation is selected.
`timescale 1ns/1ps
`default_nettype none
module reader_test_observation_access (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic spi_ss_n,
  input  wire logic spi_sclk,
  input  wire logic spi_mosi,
  output var  logic spi_miso,
  output var  logic spi_miso_oe,
  input  wire logic ready_enable,
  input  wire logic reg_external_sel,
  input  wire logic am_analog,
  input  wire logic am_digital,
  input  wire logic pm_analog,
  input  wire logic pm_digital,
  input  wire logic pm_enabled,
  input  wire logic am_stage_one,
  input  wire logic am_stage_two,
  input  wire logic pm_stage_one,
  input  wire logic pm_stage_two,
  input  wire logic channel_select_logic,
  input  wire logic coll_avoid_detect,
  input  wire logic tx_modulation,
  input  wire logic pm_select,
  output var  logic observation_pin_one,
  output var  logic observation_pin_one_oe,
  output var  logic observation_pin_two,
  output var  logic observation_pin_two_oe,
  output var  logic coll_avoid_enable,
  output var  logic adjust_reg_start,
  output var  logic power_down
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // order: ss_n, sclk, mosi; a change counts only once stages two and three agree
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  logic [2:0] stable_reg;
  logic [2:0] stable_next;
  wire  [2:0] agree = ~(sync2_reg ^ sync3_reg);

  assign stable_next = (sync3_reg & agree) | (stable_reg & ~agree);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync1_reg  <= 3'h7;
      sync2_reg  <= 3'h7;
      sync3_reg  <= 3'h7;
      stable_reg <= 3'h7;
    end else begin
      sync1_reg  <= {spi_ss_n, spi_sclk, spi_mosi};
      sync2_reg  <= sync1_reg;
      sync3_reg  <= sync2_reg;
      stable_reg <= stable_next;
    end
  end

  wire ss_fall   = stable_reg[2] & ~stable_next[2];
  wire ss_rise   = ~stable_reg[2] & stable_next[2];
  wire selected  = ~stable_reg[2];
  wire sclk_rise = selected & ~stable_reg[1] & stable_next[1];
  wire sclk_fall = selected & stable_reg[1] & ~stable_next[1];
  wire mosi_bit  = stable_next[0];

  // ----------------------------------------
  // serial frame decode
  // ----------------------------------------
  typedef enum logic [2:0] {IDLE_ST, CMD_ST, WRITE_ST, READ_ST, SKIP_ST} frame_type;

  frame_type  state_reg;
  frame_type  state_next;
  logic [2:0] bit_cnt_reg;
  logic [7:0] rx_shift_reg;
  logic [7:0] tx_shift_reg;
  logic [5:0] addr_reg;
  logic       test_mode_reg;
  logic [7:0] obs_reg;

  function automatic logic [7:0] test_read(input logic [5:0] addr, input logic open,
                                           input logic [7:0] obs);
    test_read = (open && addr == test_obs_pkg::OBS_ADDR) ? (obs & test_obs_pkg::OBS_WR_MASK)
                                                         : 8'h00;
  endfunction : test_read

  wire       byte_done = sclk_rise & (bit_cnt_reg == 3'h7);
  wire [7:0] byte_in   = {rx_shift_reg[6:0], mosi_bit};
  wire [1:0] mode_in   = byte_in[test_obs_pkg::MODE_MSB:test_obs_pkg::MODE_LSB];
  wire [5:0] code_in   = byte_in[test_obs_pkg::ADDR_MSB:0];
  wire       head_done = byte_done & (state_reg == CMD_ST);
  wire       cmd_done  = head_done & (mode_in == test_obs_pkg::MODE_COMMAND);
  wire       open_cmd  = cmd_done & (code_in == test_obs_pkg::CMD_TEST_ACCESS);
  wire       clear_cmd = cmd_done & (code_in == test_obs_pkg::CMD_CLEAR_TEST);
  wire       adj_cmd   = cmd_done & (code_in == test_obs_pkg::CMD_ADJUST_REG);
  wire       addr_open = test_mode_reg & (addr_reg == test_obs_pkg::OBS_ADDR);
  wire       obs_write = byte_done & (state_reg == WRITE_ST) & addr_open;
  wire [5:0] rd_addr   = head_done ? code_in : addr_reg + 6'h01;
  wire [7:0] rd_data   = test_read(rd_addr, test_mode_reg, obs_reg);

  always_comb begin
    state_next = state_reg;
    if (ss_fall) begin
      state_next = CMD_ST;
    end else if (ss_rise) begin
      state_next = IDLE_ST;
    end else if (head_done) begin
      case (mode_in)
        test_obs_pkg::MODE_WRITE:   state_next = WRITE_ST;
        test_obs_pkg::MODE_READ:    state_next = READ_ST;
        test_obs_pkg::MODE_COMMAND: state_next = open_cmd ? CMD_ST : SKIP_ST;
        default:                    state_next = SKIP_ST;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg     <= IDLE_ST;
      bit_cnt_reg   <= 3'h0;
      rx_shift_reg  <= 8'h00;
      tx_shift_reg  <= 8'h00;
      addr_reg      <= 6'h00;
      test_mode_reg <= 1'b0;
      spi_miso      <= 1'b0;
      spi_miso_oe   <= 1'b0;
    end else begin
      state_reg   <= state_next;
      spi_miso_oe <= ~stable_next[2];
      if (ss_fall) begin
        bit_cnt_reg   <= 3'h0;
        test_mode_reg <= 1'b0;
      end else if (sclk_rise) begin
        bit_cnt_reg  <= bit_cnt_reg + 3'h1;
        rx_shift_reg <= byte_in;
      end
      if (open_cmd) begin
        test_mode_reg <= 1'b1;
      end
      if (head_done) begin
        addr_reg <= code_in;
      end else if (byte_done && (state_reg == WRITE_ST || state_reg == READ_ST)) begin
        addr_reg <= addr_reg + 6'h01;
      end
      // bit 0 is still on the line as the byte completes, so miso only moves on a fall
      if (byte_done && (head_done || state_reg == READ_ST)) begin
        tx_shift_reg <= rd_data;
      end
      if (sclk_fall) begin
        spi_miso <= tx_shift_reg[3'h7 - bit_cnt_reg];
      end
    end
  end

  // ----------------------------------------
  // test register and commands
  // ----------------------------------------
  // only power-up, the clear command and test register writes touch it; frame ends leave it alone
  always_ff @(posedge sys_clk) begin
    if (sys_rst || clear_cmd) begin
      obs_reg <= test_obs_pkg::OBS_RESET;
    end else if (obs_write) begin
      obs_reg <= byte_in & test_obs_pkg::OBS_WR_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      adjust_reg_start <= 1'b0;
      power_down       <= 1'b1;
    end else begin
      adjust_reg_start <= adj_cmd & ~reg_external_sel;
      power_down       <= ~ready_enable;
    end
  end

  // ----------------------------------------
  // observation routing
  // ----------------------------------------
  // works regardless of test mode, so software can watch the channels live
  wire [3:0] sel       = obs_reg[test_obs_pkg::SEL_MSB:test_obs_pkg::SEL_LSB];
  wire       stage_one = pm_enabled ? pm_stage_one : am_stage_one;
  wire       stage_two = pm_enabled ? pm_stage_two : am_stage_two;
  logic      pin_one;
  logic      pin_two;
  logic      pins_on;

  always_comb begin
    pins_on = 1'b1;
    case (sel)
      test_obs_pkg::SEL_AM_PAIR:      {pin_one, pin_two} = {am_analog, am_digital};
      test_obs_pkg::SEL_PM_PAIR:      {pin_one, pin_two} = {pm_analog, pm_digital};
      test_obs_pkg::SEL_ANALOG_BOTH:  {pin_one, pin_two} = {am_analog, pm_analog};
      test_obs_pkg::SEL_DIGITAL_BOTH: {pin_one, pin_two} = {am_digital, pm_digital};
      test_obs_pkg::SEL_STAGES:       {pin_one, pin_two} = {stage_one, stage_two};
      test_obs_pkg::SEL_COLL_AVOID:   {pin_one, pin_two} = {channel_select_logic,
                                                             coll_avoid_detect};
      test_obs_pkg::SEL_TX_MOD:       {pin_one, pin_two} = {tx_modulation, pm_select};
      default: begin
        {pin_one, pin_two} = 2'h0;
        pins_on            = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      observation_pin_one    <= 1'b0;
      observation_pin_two    <= 1'b0;
      observation_pin_one_oe <= 1'b0;
      observation_pin_two_oe <= 1'b0;
      coll_avoid_enable      <= 1'b0;
    end else begin
      observation_pin_one    <= pin_one;
      observation_pin_two    <= pin_two;
      observation_pin_one_oe <= pins_on;
      observation_pin_two_oe <= pins_on;
      coll_avoid_enable      <= (sel == test_obs_pkg::SEL_COLL_AVOID);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  normal_write_blocked_a: assert property (byte_done && state_reg == WRITE_ST && !test_mode_reg
    |=> $stable(obs_reg)) else $error("write landed without test access");
  chain_opens_a: assert property (open_cmd |=> test_mode_reg && state_reg == CMD_ST)
    else $error("test access did not open chain");
  frame_end_keeps_a: assert property (ss_rise && !clear_cmd |=> $stable(obs_reg))
    else $error("deselect changed test register");
  clear_cmd_a: assert property (clear_cmd |=> obs_reg == 8'h00)
    else $error("clear command missed");
  upper_bits_zero_a: assert property (obs_reg[7:4] == 4'h0)
    else $error("unused bits set");
  am_pair_route_a: assert property (sel == 4'h1 |=> observation_pin_one == $past(am_analog)
    && observation_pin_two == $past(am_digital)) else $error("am pair misrouted");
  stage_source_a: assert property (sel == 4'h5 && pm_enabled
    |=> observation_pin_two == $past(pm_stage_two)) else $error("stage source wrong");
  coll_enable_a: assert property (sel == 4'h9 |=> coll_avoid_enable && observation_pin_two_oe)
    else $error("collision detectors not enabled");
  tx_mod_route_a: assert property (sel == 4'ha |=> observation_pin_one == $past(tx_modulation)
    && observation_pin_two == $past(pm_select)) else $error("tx pair misrouted");
  reset_state_a: assert property ($fell(sys_rst) |-> power_down && obs_reg == 8'h00)
    else $error("not in power-down after reset");
  adjust_refused_a: assert property (adj_cmd && reg_external_sel |=> !adjust_reg_start)
    else $error("adjust ran with external regulation");
  idle_pins_a: assert property (sel == 4'h0 |=> !observation_pin_one_oe
    && !observation_pin_two_oe && !observation_pin_one) else $error("pins driven idle");
endmodule : reader_test_observation_access
`default_nettype wire

// file: tb/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host side of the serial bus
// ----------------------------------------
module spi_host_model (
  input  wire logic sys_clk,
  input  wire logic miso,
  output var  logic ss_n,
  output var  logic sclk,
  output var  logic mosi
);
  logic [7:0] tx_buf [4];
  logic [7:0] rx_buf [4];
  initial begin
    ss_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // slow sclk: each half is 8 sys_clk so the 3-stage filter keeps up
  task run_frame(input int n);
    int i;
    int b;
    @(posedge sys_clk) #1 ss_n = 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    for (i = 0; i < n; i++) begin
      for (b = 7; b >= 0; b--) begin
        mosi = tx_buf[i][b];
        repeat (8) @(posedge sys_clk);
        #1 sclk = 1'b1;
        repeat (8) @(posedge sys_clk);
        #1 rx_buf[i][b] = miso;
        sclk = 1'b0;
      end
    end
    repeat (8) @(posedge sys_clk);
    #1 ss_n = 1'b1;
    mosi = ~mosi;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask : run_frame
endmodule : spi_host_model
`default_nettype wire

// file: tb/test_reader_test_observation_access.sv
`timescale 1ns/1ps
`default_nettype none
module test_reader_test_observation_access;
  logic        sys_clk;
  logic        sys_rst;
  logic        ready_enable;
  logic        reg_external_sel;
  logic [12:0] obs_in;
  logic        ss_n;
  logic        sclk;
  logic        mosi;
  logic        miso;
  logic        miso_oe;
  logic        idle_toggle = 1'b0;
  logic        p1;
  logic        p1_oe;
  logic        p2;
  logic        p2_oe;
  logic        cae;
  logic        adj;
  logic        power_down;
  int          n_errors;
  int          tests_run;
  int          adj_count;
  logic [7:0]  v;
  // host power-up frames: header bytes, addresses and codes arbitrary
  localparam logic [7:0] IO_CFG_WRITE = 8'h00;
  localparam logic [7:0] DEPTH_WRITE  = 8'h11;
  localparam logic [7:0] CAL_ANTENNA  = 8'he1;
  localparam logic [7:0] CAL_DEPTH    = 8'he2;
  // ----------------------------------------
  // clock, idle line, design
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // released miso shows a moving pattern, never the last bit
  always @(posedge sys_clk) idle_toggle <= ~idle_toggle;
  wire miso_line = (miso_oe === 1'b1) ? miso : idle_toggle;
  always @(posedge sys_clk) if (adj === 1'b1) adj_count++;
  reader_test_observation_access reader_test_observation_access_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .spi_ss_n(ss_n), .spi_sclk(sclk),
    .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe),
    .ready_enable(ready_enable), .reg_external_sel(reg_external_sel),
    .am_analog(obs_in[0]), .am_digital(obs_in[1]), .pm_analog(obs_in[2]),
    .pm_digital(obs_in[3]), .pm_enabled(obs_in[4]), .am_stage_one(obs_in[5]),
    .am_stage_two(obs_in[6]), .pm_stage_one(obs_in[7]), .pm_stage_two(obs_in[8]),
    .channel_select_logic(obs_in[9]), .coll_avoid_detect(obs_in[10]),
    .tx_modulation(obs_in[11]), .pm_select(obs_in[12]),
    .observation_pin_one(p1), .observation_pin_one_oe(p1_oe),
    .observation_pin_two(p2), .observation_pin_two_oe(p2_oe),
    .coll_avoid_enable(cae), .adjust_reg_start(adj), .power_down(power_down));
  spi_host_model spi_host_model_inst (
    .sys_clk(sys_clk), .miso(miso_line), .ss_n(ss_n), .sclk(sclk), .mosi(mosi));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task test_done;
    $display("errors %0d of %0d compares", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task xfer(input int n, input logic [7:0] a, b, c, d);
    spi_host_model_inst.tx_buf = '{a, b, c, d};
    spi_host_model_inst.run_frame(n);
  endtask : xfer
  // {oe1, pin1, oe2, pin2, detector enable}
  function automatic logic [4:0] exp_obs(input logic [3:0] c, input logic [12:0] s);
    case (c)
      4'h1: return {1'b1, s[0], 1'b1, s[1], 1'b0};
      4'h2: return {1'b1, s[2], 1'b1, s[3], 1'b0};
      4'h3: return {1'b1, s[0], 1'b1, s[2], 1'b0};
      4'h4: return {1'b1, s[1], 1'b1, s[3], 1'b0};
      4'h5: return s[4] ? {1'b1, s[7], 1'b1, s[8], 1'b0} : {1'b1, s[5], 1'b1, s[6], 1'b0};
      4'h9: return {1'b1, s[9], 1'b1, s[10], 1'b1};
      4'ha: return {1'b1, s[11], 1'b1, s[12], 1'b0};
      default: return 5'h00;
    endcase
  endfunction : exp_obs
  task check_pins(input logic [3:0] c);
    check({3'h0, p1_oe, p1, p2_oe, p2, cae}, {3'h0, exp_obs(c, obs_in)});
  endtask : check_pins
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    // about three times the expected run length
    repeat (40000) @(posedge sys_clk);
    n_errors++;
    test_done();
  end
  initial begin
    n_errors = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    ready_enable = 1'b0;
    reg_external_sel = 1'b0;
    obs_in = 13'h0000;
    void'($urandom(35766));
    repeat (4) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 check({7'h00, power_down}, 8'h01);
    check_pins(4'h0);
    ready_enable = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 check({7'h00, power_down}, 8'h00);
    // power-up order: io config, regulators, antenna, modulation depth
    xfer(3, IO_CFG_WRITE, 8'($urandom), 8'($urandom), 8'h00);
    xfer(1, 8'hd6, 8'h00, 8'h00, 8'h00);
    xfer(1, CAL_ANTENNA, 8'h00, 8'h00, 8'h00);
    xfer(2, DEPTH_WRITE, 8'($urandom), 8'h00, 8'h00);
    xfer(1, CAL_DEPTH, 8'h00, 8'h00, 8'h00);
    check(8'(adj_count), 8'h01);
    check_pins(4'h0);
    xfer(2, 8'h01, 8'h05, 8'h00, 8'h00);
    xfer(3, 8'hfc, 8'h41, 8'h00, 8'h00);
    check(spi_host_model_inst.rx_buf[2], 8'h00);
    for (int k = 0; k < 2; k++) begin
      v = (k == 0) ? 8'hff : 8'($urandom);
      xfer(4, 8'hfc, 8'h01, v, 8'($urandom));
      xfer(4, 8'hfc, 8'h41, 8'h00, 8'h00);
      check(spi_host_model_inst.rx_buf[2], v & 8'h0f);
      check(spi_host_model_inst.rx_buf[3], 8'h00);
    end
    for (int c = 0; c < 16; c++) begin
      xfer(3, 8'hfc, 8'h01, {4'($urandom), 4'(c)}, 8'h00);
      for (int r = 0; r < 6; r++) begin
        obs_in = 13'($urandom);
        repeat (3) @(posedge sys_clk);
        #1 check_pins(4'(c));
      end
    end
    xfer(2, 8'hfc, 8'hea, 8'h00, 8'h00);
    xfer(3, 8'hfc, 8'h41, 8'h00, 8'h00);
    check(spi_host_model_inst.rx_buf[2], 8'h00);
    check_pins(4'h0);
    reg_external_sel = 1'b1;
    xfer(1, 8'hd6, 8'h00, 8'h00, 8'h00);
    check(8'(adj_count), 8'h01);
    reg_external_sel = 1'b0;
    xfer(1, 8'hd6, 8'h00, 8'h00, 8'h00);
    check(8'(adj_count), 8'h02);
    xfer(3, 8'hfc, 8'h01, 8'h03, 8'h00);
    sys_rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 check_pins(4'h0);
    xfer(3, 8'hfc, 8'h41, 8'h00, 8'h00);
    check(spi_host_model_inst.rx_buf[2], 8'h00);
    test_done();
  end
endmodule : test_reader_test_observation_access
`default_nettype wire
